// file: sracc_pkg.sv
// Shared constants, types and helpers for the SYSREF capture and
// calibration control block.
// Assumes a single device clock domain and an 8-bit register port.
package sracc_pkg;

  localparam int AW = 8;
  localparam int DW = 8;
  localparam int SAMPLE_W = 12;
  localparam int IQ_W = 15;
  localparam int NUM_CORES = 5;
  localparam int DELAY_TAPS = 16;
  localparam int CNT_W = 28;

  // Register offsets
  localparam logic [AW-1:0] ADDR_CAPTURE_CTRL = 8'h30;
  localparam logic [AW-1:0] ADDR_CAPTURE_STAT = 8'h31;
  localparam logic [AW-1:0] ADDR_DELAY_SEL = 8'h32;
  localparam logic [AW-1:0] ADDR_DDC_CONFIG = 8'h40;
  localparam logic [AW-1:0] ADDR_NCO_STEP = 8'h41;
  localparam logic [AW-1:0] ADDR_LINK_CTRL = 8'h42;
  localparam logic [AW-1:0] ADDR_OFFSET_ADJ = 8'h43;
  localparam logic [AW-1:0] ADDR_CAL_START = 8'h50;
  localparam logic [AW-1:0] ADDR_BG_CAL_CFG = 8'h57;
  localparam logic [AW-1:0] ADDR_TIMING_CFG = 8'h66;

  // Field positions
  localparam int BIT_RCVR_ON = 7;
  localparam int BIT_PROC_ON = 6;
  localparam int BIT_SEEN_CLR = 5;
  localparam int BIT_FAULT_CLR = 4;
  localparam int BIT_SEEN_FLAG = 7;
  localparam int BIT_FAULT_FLAG = 6;
  localparam int BIT_CAL_BUSY = 7;
  localparam int BIT_CAL_START = 3;
  localparam int BIT_BG_SEL = 0;
  localparam int BIT_CONT_SEL = 1;
  localparam int BIT_TIMING_CAL = 0;
  localparam int BIT_LINK_ON = 0;

  // Values after reset
  localparam logic [DW-1:0] RST_CAPTURE_CTRL = 8'h00;
  localparam logic [DW-1:0] RST_DELAY_SEL = 8'h00;
  localparam logic [DW-1:0] RST_DDC_CONFIG = 8'h00;
  localparam logic [DW-1:0] RST_NCO_STEP = 8'h00;
  localparam logic [DW-1:0] RST_LINK_CTRL = 8'h00;
  localparam logic [DW-1:0] RST_OFFSET_ADJ = 8'h00;
  localparam logic [DW-1:0] RST_CAL_START = 8'h00;
  localparam logic [DW-1:0] RST_BG_CAL_CFG = 8'h00;
  localparam logic [DW-1:0] RST_TIMING_CFG = 8'h00;

  // Cycle counts in device clock cycles
  localparam int FG_CAL_CYCLES_DEF = 102000000;
  localparam int TIMING_CAL_CYCLES_DEF = 125000000;
  localparam int BG_SWAP_CYCLES_DEF = 163200000;

  localparam logic [SAMPLE_W-1:0] STATIC_CODE = 12'h800;

  typedef enum logic [2:0] {
    SRACC_DEC_1 = 3'b000,
    SRACC_DEC_4 = 3'b001,
    SRACC_DEC_8 = 3'b010,
    SRACC_DEC_10 = 3'b011,
    SRACC_DEC_16 = 3'b100,
    SRACC_DEC_20 = 3'b101,
    SRACC_DEC_32 = 3'b110
  } sracc_dec_t;

  typedef enum logic [1:0] {
    SRACC_CAL_IDLE = 2'b00,
    SRACC_CAL_FG = 2'b01,
    SRACC_CAL_TIMING = 2'b10,
    SRACC_CAL_BG = 2'b11
  } sracc_cal_t;

  function automatic logic [5:0] sracc_dec_factor(input logic [2:0] code);
    case (code)
      SRACC_DEC_4: sracc_dec_factor = 6'h04;
      SRACC_DEC_8: sracc_dec_factor = 6'h08;
      SRACC_DEC_10: sracc_dec_factor = 6'h0A;
      SRACC_DEC_16: sracc_dec_factor = 6'h10;
      SRACC_DEC_20: sracc_dec_factor = 6'h14;
      SRACC_DEC_32: sracc_dec_factor = 6'h20;
      default: sracc_dec_factor = 6'h01;
    endcase
  endfunction

endpackage

// file: sracc_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to mclk; bits are not coherent.
`timescale 1ns/1ps
module sracc_sync #(
  parameter int W = 2
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// file: sracc_delay.sv
// Selectable delay line for the SYSREF level and its timing-window
// fault level, with rising-edge capture on the selected tap.
// Assumes both inputs are already synchronous to mclk.
`timescale 1ns/1ps
module sracc_delay #(
  parameter int TAPS = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sysref_lvl,
  input wire logic window_fault_lvl,
  input wire logic [$clog2(TAPS)-1:0] tap_sel,
  output logic edge_seen,
  output logic edge_fault
);

  logic [TAPS-1:0] ref_line_reg;
  logic [TAPS-1:0] flt_line_reg;
  logic prev_reg;
  logic tap_ref;
  logic tap_flt;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ref_line_reg <= '0;
      flt_line_reg <= '0;
    end else begin
      ref_line_reg <= {ref_line_reg[TAPS-2:0], sysref_lvl};
      flt_line_reg <= {flt_line_reg[TAPS-2:0], window_fault_lvl};
    end
  end

  assign tap_ref = ref_line_reg[tap_sel];
  assign tap_flt = flt_line_reg[tap_sel];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= tap_ref;
    end
  end

  // Fault shares the edge's delay
  assign edge_seen = tap_ref & ~prev_reg;
  assign edge_fault = tap_ref & ~prev_reg & tap_flt;

endmodule

// file: sracc_top.sv
// SYSREF capture, NCO/DDC output selection and calibration sequencing.
// Assumes registers are driven on mclk; SYSREF pins are asynchronous.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
// Contract
// - Sticky flag on delayed SYSREF rising edge
// - Sticky flag on setup or hold failure
// - Seen-clear bit clears detected flag
// - Fault-clear bit clears capture fault flag
// - Four-bit field sets SYSREF delay
// - Receiver enable and processing enable bits
// - NCO phase reset during lane alignment; here only while decimation is above one (ddc_active)
// - Decimation one outputs raw 12-bit samples
// - Higher decimation outputs reduced-rate I/Q
// - Foreground calibration forces static output code
// - Self-clearing start bit runs bounded calibration
// - Start resets cal logic; relink afterwards
// - Background keeps five cores, swaps one
// - Background swap rate fixed internally
// - Offset adjust ignored in background mode
// - Timing calibration off at reset, optional
module sracc_top
  import sracc_pkg::*;
#(
  parameter int FG_CAL_CYCLES = sracc_pkg::FG_CAL_CYCLES_DEF,
  parameter int TIMING_CAL_CYCLES = sracc_pkg::TIMING_CAL_CYCLES_DEF,
  parameter int BG_SWAP_CYCLES = sracc_pkg::BG_SWAP_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [sracc_pkg::AW-1:0] reg_addr,
  input wire logic [sracc_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sracc_pkg::DW-1:0] reg_rdata,
  input wire logic sysref_in,
  input wire logic sysref_window_fault_in,
  input wire logic ila_active,
  input wire logic [sracc_pkg::SAMPLE_W-1:0] adc_sample,
  output logic lmfc_align,
  output logic nco_reset,
  output logic ddc_active,
  output logic sample_out_valid,
  output logic [sracc_pkg::SAMPLE_W-1:0] raw_out,
  output logic [sracc_pkg::IQ_W-1:0] i_out,
  output logic [sracc_pkg::IQ_W-1:0] q_out,
  output logic cal_busy,
  output logic cal_logic_reset,
  output logic timing_cal_active,
  output logic [sracc_pkg::NUM_CORES-1:0] core_powered,
  output logic [sracc_pkg::NUM_CORES-1:0] core_online,
  output logic [sracc_pkg::DW-1:0] offset_adjust_eff,
  output logic sysref_receiver_on,
  output logic serial_link_on
);

  import sracc_pkg::*;

  localparam logic [CNT_W-1:0] FG_LAST = CNT_W'(FG_CAL_CYCLES - 1);
  localparam logic [CNT_W-1:0] TM_LAST = CNT_W'(TIMING_CAL_CYCLES - 1);
  localparam logic [CNT_W-1:0] BG_LAST = CNT_W'(BG_SWAP_CYCLES - 1);
  localparam logic [2:0] LAST_CORE = 3'(NUM_CORES - 1);

  logic [DW-1:0] capture_ctrl_reg;
  logic [DW-1:0] delay_sel_reg;
  logic [DW-1:0] ddc_config_reg;
  logic [DW-1:0] nco_step_reg;
  logic [DW-1:0] link_ctrl_reg;
  logic [DW-1:0] offset_adj_reg;
  logic [DW-1:0] cal_start_reg;
  logic [DW-1:0] bg_cal_cfg_reg;
  logic [DW-1:0] timing_cfg_reg;
  logic [DW-1:0] rdata_reg;
  logic sysref_seen_flag;
  logic capture_fault_flag;

  logic [1:0] pins_sync;
  logic sysref_gated;
  logic fault_gated;
  logic edge_seen;
  logic edge_fault;

  logic wr_ctrl;
  logic cal_start;
  logic background_cal_sel;
  logic continuous_cal_sel;
  logic bg_mode;
  logic sysref_processing_on;
  logic sysref_seen_clear;
  logic capture_fault_clear;

  sracc_cal_t cal_state_reg;
  logic [CNT_W-1:0] cal_cnt_reg;
  logic timing_latched_reg;
  logic cal_reset_reg;
  logic [2:0] offline_core_reg;
  logic in_fg_cal;

  logic [15:0] nco_phase_reg;
  logic [5:0] dec_cnt_reg;
  logic [5:0] dec_last;
  logic signed [IQ_W-1:0] sample_s;
  logic signed [IQ_W-1:0] sample_neg;
  logic valid_reg;
  logic [SAMPLE_W-1:0] raw_reg;
  logic [IQ_W-1:0] i_reg;
  logic [IQ_W-1:0] q_reg;

  // Register writes
  assign wr_ctrl = reg_wr && (reg_addr == ADDR_CAPTURE_CTRL);
  assign cal_start = reg_wr && (reg_addr == ADDR_CAL_START) &&
                     reg_wdata[BIT_CAL_START];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      capture_ctrl_reg <= RST_CAPTURE_CTRL;
      delay_sel_reg <= RST_DELAY_SEL;
      ddc_config_reg <= RST_DDC_CONFIG;
      nco_step_reg <= RST_NCO_STEP;
      link_ctrl_reg <= RST_LINK_CTRL;
      offset_adj_reg <= RST_OFFSET_ADJ;
      cal_start_reg <= RST_CAL_START;
      bg_cal_cfg_reg <= RST_BG_CAL_CFG;
      timing_cfg_reg <= RST_TIMING_CFG;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_CAPTURE_CTRL) begin
        capture_ctrl_reg <= reg_wdata;
      end else if (reg_addr == ADDR_DELAY_SEL) begin
        delay_sel_reg <= {4'h0, reg_wdata[3:0]};
      end else if (reg_addr == ADDR_DDC_CONFIG) begin
        ddc_config_reg <= {5'h00, reg_wdata[2:0]};
      end else if (reg_addr == ADDR_NCO_STEP) begin
        nco_step_reg <= reg_wdata;
      end else if (reg_addr == ADDR_LINK_CTRL) begin
        link_ctrl_reg <= {7'h00, reg_wdata[BIT_LINK_ON]};
      end else if (reg_addr == ADDR_OFFSET_ADJ) begin
        offset_adj_reg <= reg_wdata;
      end else if (reg_addr == ADDR_CAL_START) begin
        // Start bit is never stored: it reads back as zero
        cal_start_reg <= {1'b0, reg_wdata[6:4], 1'b0,
                          reg_wdata[2:0]};
      end else if (reg_addr == ADDR_BG_CAL_CFG) begin
        bg_cal_cfg_reg <= reg_wdata;
      end else if (reg_addr == ADDR_TIMING_CFG) begin
        timing_cfg_reg <= reg_wdata;
      end
    end
  end

  assign sysref_receiver_on = capture_ctrl_reg[BIT_RCVR_ON];
  assign sysref_processing_on = capture_ctrl_reg[BIT_PROC_ON];
  assign sysref_seen_clear = capture_ctrl_reg[BIT_SEEN_CLR];
  assign capture_fault_clear = capture_ctrl_reg[BIT_FAULT_CLR];
  assign background_cal_sel = bg_cal_cfg_reg[BIT_BG_SEL];
  assign continuous_cal_sel = bg_cal_cfg_reg[BIT_CONT_SEL];
  // Both bits are needed; either alone stays in foreground mode
  assign bg_mode = background_cal_sel && continuous_cal_sel;
  assign serial_link_on = link_ctrl_reg[BIT_LINK_ON];

  // SYSREF capture path
  sracc_sync #(
    .W(2)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({sysref_window_fault_in, sysref_in}),
    .sync_out(pins_sync)
  );

  // Receiver off: the delay line sees a quiet input
  assign sysref_gated = pins_sync[0] & sysref_receiver_on;
  assign fault_gated = pins_sync[1] & sysref_receiver_on;

  sracc_delay #(
    .TAPS(DELAY_TAPS)
  ) u_delay (
    .mclk(mclk),
    .rst_n(rst_n),
    .sysref_lvl(sysref_gated),
    .window_fault_lvl(fault_gated),
    .tap_sel(delay_sel_reg[3:0]),
    .edge_seen(edge_seen),
    .edge_fault(edge_fault)
  );

  // A held clear bit wins over a new event
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sysref_seen_flag <= 1'b0;
    end else if (sysref_seen_clear) begin
      sysref_seen_flag <= 1'b0;
    end else if (edge_seen) begin
      sysref_seen_flag <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      capture_fault_flag <= 1'b0;
    end else if (capture_fault_clear) begin
      capture_fault_flag <= 1'b0;
    end else if (edge_fault) begin
      capture_fault_flag <= 1'b1;
    end
  end

  // Alignment only on clean captures with processing enabled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lmfc_align <= 1'b0;
    end else begin
      lmfc_align <= edge_seen && !edge_fault && sysref_processing_on;
    end
  end

  // Calibration sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cal_state_reg <= SRACC_CAL_IDLE;
      cal_cnt_reg <= '0;
      timing_latched_reg <= 1'b0;
      cal_reset_reg <= 1'b0;
    end else if (cal_start) begin
      // Restart wipes any run in progress
      cal_state_reg <= SRACC_CAL_FG;
      cal_cnt_reg <= '0;
      timing_latched_reg <= timing_cfg_reg[BIT_TIMING_CAL];
      cal_reset_reg <= 1'b1;
    end else begin
      cal_reset_reg <= 1'b0;
      case (cal_state_reg)
        SRACC_CAL_FG: begin
          if (cal_cnt_reg == FG_LAST) begin
            cal_cnt_reg <= '0;
            if (timing_latched_reg) begin
              cal_state_reg <= SRACC_CAL_TIMING;
            end else if (bg_mode) begin
              cal_state_reg <= SRACC_CAL_BG;
            end else begin
              cal_state_reg <= SRACC_CAL_IDLE;
            end
          end else begin
            cal_cnt_reg <= cal_cnt_reg + 1'b1;
          end
        end
        SRACC_CAL_TIMING: begin
          if (cal_cnt_reg == TM_LAST) begin
            cal_cnt_reg <= '0;
            cal_state_reg <= bg_mode ? SRACC_CAL_BG : SRACC_CAL_IDLE;
          end else begin
            cal_cnt_reg <= cal_cnt_reg + 1'b1;
          end
        end
        SRACC_CAL_BG: begin
          if (!bg_mode) begin
            cal_state_reg <= SRACC_CAL_IDLE;
            cal_cnt_reg <= '0;
          end else if (cal_cnt_reg == BG_LAST) begin
            cal_cnt_reg <= '0;
          end else begin
            cal_cnt_reg <= cal_cnt_reg + 1'b1;
          end
        end
        default: begin
          cal_cnt_reg <= '0;
        end
      endcase
    end
  end

  // Rotation of the offline core; one-cycle swap keeps data flowing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      offline_core_reg <= LAST_CORE;
    end else if (cal_start) begin
      offline_core_reg <= LAST_CORE;
    end else if (cal_state_reg == SRACC_CAL_BG && bg_mode &&
                 cal_cnt_reg == BG_LAST) begin
      if (offline_core_reg == LAST_CORE) begin
        offline_core_reg <= 3'h0;
      end else begin
        offline_core_reg <= offline_core_reg + 3'h1;
      end
    end
  end

  assign in_fg_cal = (cal_state_reg == SRACC_CAL_FG) ||
                     (cal_state_reg == SRACC_CAL_TIMING);
  assign cal_busy = in_fg_cal;
  assign cal_logic_reset = cal_reset_reg;
  assign timing_cal_active = (cal_state_reg == SRACC_CAL_TIMING);
  // Fifth core only draws power in background mode
  assign core_powered = bg_mode ? 5'h1F : 5'h0F;
  assign core_online = (cal_state_reg == SRACC_CAL_BG) ?
                       (5'h1F & ~(5'h01 << offline_core_reg)) :
                       (in_fg_cal ? 5'h00 : 5'h0F);
  assign offset_adjust_eff = bg_mode ? 8'h00 : offset_adj_reg;

  // NCO and decimation
  assign dec_last = sracc_dec_factor(ddc_config_reg[2:0]) - 6'h01;
  assign ddc_active = (sracc_dec_factor(ddc_config_reg[2:0]) != 6'h01);
  assign nco_reset = ila_active && ddc_active;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nco_phase_reg <= 16'h0000;
    end else if (nco_reset) begin
      nco_phase_reg <= 16'h0000;
    end else begin
      nco_phase_reg <= nco_phase_reg + {8'h00, nco_step_reg};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dec_cnt_reg <= 6'h00;
    end else if (dec_cnt_reg >= dec_last) begin
      dec_cnt_reg <= 6'h00;
    end else begin
      dec_cnt_reg <= dec_cnt_reg + 6'h01;
    end
  end

  // Offset binary to signed, plus offset trim
  assign sample_s = IQ_W'($signed({~adc_sample[SAMPLE_W-1],
                                    adc_sample[SAMPLE_W-2:0]})) +
                    IQ_W'($signed(offset_adjust_eff));
  assign sample_neg = -sample_s;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      valid_reg <= 1'b0;
      raw_reg <= STATIC_CODE;
      i_reg <= '0;
      q_reg <= '0;
    end else begin
      valid_reg <= (dec_cnt_reg >= dec_last);
      if (in_fg_cal) begin
        raw_reg <= STATIC_CODE;
        i_reg <= '0;
        q_reg <= '0;
      end else if (!ddc_active) begin
        // Trim can wrap at full scale; bypass keeps the raw width
        raw_reg <= {~sample_s[SAMPLE_W-1], sample_s[SAMPLE_W-2:0]};
        i_reg <= '0;
        q_reg <= '0;
      end else if (dec_cnt_reg >= dec_last) begin
        raw_reg <= STATIC_CODE;
        // Quadrant mixer: coarse, but phase-exact after reset
        case (nco_phase_reg[15:14])
          2'b00: begin
            i_reg <= sample_s;
            q_reg <= '0;
          end
          2'b01: begin
            i_reg <= '0;
            q_reg <= sample_neg;
          end
          2'b10: begin
            i_reg <= sample_neg;
            q_reg <= '0;
          end
          default: begin
            i_reg <= '0;
            q_reg <= sample_s;
          end
        endcase
      end
    end
  end

  assign sample_out_valid = valid_reg;
  assign raw_out = raw_reg;
  assign i_out = i_reg;
  assign q_out = q_reg;

  // Register reads, data one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_CAPTURE_CTRL) begin
        rdata_reg <= capture_ctrl_reg;
      end else if (reg_addr == ADDR_CAPTURE_STAT) begin
        rdata_reg <= {sysref_seen_flag, capture_fault_flag, 6'h00};
      end else if (reg_addr == ADDR_DELAY_SEL) begin
        rdata_reg <= delay_sel_reg;
      end else if (reg_addr == ADDR_DDC_CONFIG) begin
        rdata_reg <= ddc_config_reg;
      end else if (reg_addr == ADDR_NCO_STEP) begin
        rdata_reg <= nco_step_reg;
      end else if (reg_addr == ADDR_LINK_CTRL) begin
        rdata_reg <= link_ctrl_reg;
      end else if (reg_addr == ADDR_OFFSET_ADJ) begin
        rdata_reg <= offset_adj_reg;
      end else if (reg_addr == ADDR_CAL_START) begin
        rdata_reg <= cal_start_reg | {cal_busy, 7'h00};
      end else if (reg_addr == ADDR_BG_CAL_CFG) begin
        rdata_reg <= bg_cal_cfg_reg;
      end else if (reg_addr == ADDR_TIMING_CFG) begin
        rdata_reg <= timing_cfg_reg;
      end else begin
        rdata_reg <= 8'h00;
      end
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

// file: sracc_sysref_gen.sv
// Periodic SYSREF source standing in for the system clock generator.
// Assumes mclk is the device clock; edges are launched from it.
`timescale 1ns/1ps
module sracc_sysref_gen #(
  parameter int PERIOD = 32,
  parameter int HIGH = 8
) (
  input wire logic mclk,
  input wire logic run,
  input wire logic fault_on,
  output logic sysref,
  output logic window_fault
);
  int phase = 0;
  initial sysref = 1'b0;
  initial window_fault = 1'b0;
  // Fixed phase to mclk: repeatable capture
  always @(posedge mclk) begin
    phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
    sysref <= run && (phase < HIGH);
    // Violation only near the rising edge
    window_fault <= run && fault_on && (phase < 2);
  end
endmodule

// file: sracc_monitor.sv
// Port checks on sracc_top, attached by bind.
// Assumes one mclk domain.
`timescale 1ns/1ps
module sracc_monitor
  import sracc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [sracc_pkg::AW-1:0] reg_addr,
  input wire logic [sracc_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [sracc_pkg::DW-1:0] reg_rdata,
  input wire logic ila_active,
  input wire logic nco_reset,
  input wire logic ddc_active,
  input wire logic sample_out_valid,
  input wire logic [sracc_pkg::SAMPLE_W-1:0] raw_out,
  input wire logic [sracc_pkg::IQ_W-1:0] i_out,
  input wire logic cal_busy,
  input wire logic cal_logic_reset,
  input wire logic [sracc_pkg::NUM_CORES-1:0] core_powered,
  input wire logic [sracc_pkg::NUM_CORES-1:0] core_online,
  input wire logic [sracc_pkg::DW-1:0] offset_adjust_eff,
  input wire logic sysref_receiver_on
);
  logic clr_held_reg;
  logic clr_prev_reg;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Two stages, so the flag has had a cycle to drop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clr_held_reg <= 1'b0;
      clr_prev_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_CAPTURE_CTRL)
        clr_held_reg <= reg_wdata[BIT_SEEN_CLR];
      clr_prev_reg <= clr_held_reg;
    end
  end
  cal_start_a:
    assert property (reg_wr && reg_addr == ADDR_CAL_START &&
      reg_wdata[BIT_CAL_START] |=> cal_busy && cal_logic_reset)
    else $error("no busy after start");
  static_code_a:
    assert property (cal_busy && $past(cal_busy) |->
      raw_out == STATIC_CODE && i_out == '0)
    else $error("output moves in cal");
  nco_phase_a:
    assert property (nco_reset == (ila_active && ddc_active))
    else $error("bad nco reset");
  bg_online_a:
    assert property (core_powered == 5'h1F && !cal_busy |->
      $countones(core_online) == 4)
    else $error("not four cores online");
  offset_off_a:
    assert property (core_powered == 5'h1F |-> offset_adjust_eff == '0)
    else $error("offset trim in bg mode");
  ddc_rate_a:
    assert property (ddc_active && !cal_busy && sample_out_valid &&
      !reg_wr ##1 !reg_wr |-> !sample_out_valid)
    else $error("valid twice in a row");
  seen_held_a:
    assert property (reg_rd && reg_addr == ADDR_CAPTURE_STAT &&
      clr_held_reg && clr_prev_reg |=> !reg_rdata[BIT_SEEN_FLAG])
    else $error("seen flag set while clear");
  rcvr_bit_a:
    assert property (reg_wr && reg_addr == ADDR_CAPTURE_CTRL |=>
      sysref_receiver_on == $past(reg_wdata[BIT_RCVR_ON]))
    else $error("receiver bit mismatch");
  cover property (cal_logic_reset);
  cover property (core_powered == 5'h1F && !cal_busy);
  cover property (ddc_active && sample_out_valid);
endmodule

bind sracc_top sracc_monitor mon (.mclk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .ila_active, .nco_reset, .ddc_active,
  .sample_out_valid, .raw_out, .i_out, .cal_busy, .cal_logic_reset,
  .core_powered, .core_online, .offset_adjust_eff, .sysref_receiver_on);

// file: sracc_top_tb.sv
// Self-checking bench for sracc_top with a SYSREF source model.
// Assumes short cal and swap counts.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  err_count++; $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); \
  end end
module sracc_top_tb;
  import sracc_pkg::*;
  localparam int FG = 20;
  localparam int TM = 10;
  localparam int BG = 8;
  int err_count = 0;
  int samples_checked = 0;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [AW-1:0] reg_addr = '0;
  logic [DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ila_active = 1'b0;
  logic [SAMPLE_W-1:0] adc_sample = '0;
  logic run = 1'b0;
  logic fault_on = 1'b0;
  logic sysref, wfault, nco_reset, ddc_active, sample_out_valid, cal_busy;
  logic timing_cal_active, sysref_receiver_on, serial_link_on;
  logic [DW-1:0] reg_rdata, offset_adjust_eff;
  logic [SAMPLE_W-1:0] raw_out;
  logic [IQ_W-1:0] i_out, q_out;
  logic [NUM_CORES-1:0] core_powered, core_online;

  always #2 mclk = ~mclk;
  sracc_sysref_gen gen (.mclk, .run, .fault_on, .sysref,
    .window_fault(wfault));
  sracc_top #(.FG_CAL_CYCLES(FG), .TIMING_CAL_CYCLES(TM),
    .BG_SWAP_CYCLES(BG)) dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .sysref_in(sysref), .sysref_window_fault_in(wfault),
    .ila_active, .adc_sample, .lmfc_align(), .nco_reset, .ddc_active,
    .sample_out_valid, .raw_out, .i_out, .q_out, .cal_busy,
    .cal_logic_reset(), .timing_cal_active, .core_powered, .core_online,
    .offset_adjust_eff, .sysref_receiver_on, .serial_link_on);

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
    logic [DW-1:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic t_regs();
    rchk(ADDR_CAPTURE_CTRL, RST_CAPTURE_CTRL);
    rchk(ADDR_DELAY_SEL, RST_DELAY_SEL);
    rchk(ADDR_BG_CAL_CFG, RST_BG_CAL_CFG);
    rchk(ADDR_TIMING_CFG, RST_TIMING_CFG);
    rchk(8'h7F, 8'h00);
    wr(ADDR_CAPTURE_STAT, 8'hFF);
    rchk(ADDR_CAPTURE_STAT, 8'h00);
    wr(ADDR_DELAY_SEL, 8'hFF);
    rchk(ADDR_DELAY_SEL, 8'h0F);
    wr(ADDR_CAPTURE_CTRL, 8'h80);
    #1 `CHK(sysref_receiver_on, 1'b1)
  endtask
  task automatic t_capture();
    run <= 1'b1;
    wr(ADDR_CAPTURE_CTRL, 8'h00);
    cyc(64);
    rchk(ADDR_CAPTURE_STAT, 8'h00);
    fault_on <= 1'b1;
    wr(ADDR_CAPTURE_CTRL, 8'hC0);
    cyc(64);
    fault_on <= 1'b0;
    cyc(64);
    rchk(ADDR_CAPTURE_STAT, 8'hC0);
    wr(ADDR_CAPTURE_CTRL, 8'hD0);
    cyc(64);
    rchk(ADDR_CAPTURE_STAT, 8'h80);
    wr(ADDR_CAPTURE_CTRL, 8'hE0);
    cyc(64);
    rchk(ADDR_CAPTURE_STAT, 8'h00);
    wr(ADDR_CAPTURE_CTRL, 8'hC0);
    cyc(64);
    rchk(ADDR_CAPTURE_STAT, 8'h80);
  endtask
  task automatic t_sweep();
    logic [DW-1:0] d;
    int lo = -1;
    int hi = -1;
    for (int t = 0; t < DELAY_TAPS; t++) begin
      fault_on <= (t >= 12);
      wr(ADDR_DELAY_SEL, DW'(t));
      wr(ADDR_CAPTURE_CTRL, 8'hF0);
      wr(ADDR_CAPTURE_CTRL, 8'hC0);
      cyc(64);
      rd(ADDR_CAPTURE_STAT, d);
      `CHK(d, (t >= 12) ? 8'hC0 : 8'h80)
      if (d == 8'h80 && lo < 0) lo = t;
      if (d == 8'h80) hi = t;
    end
    fault_on <= 1'b0;
    wr(ADDR_DELAY_SEL, DW'((lo + hi) / 2));
    rchk(ADDR_DELAY_SEL, 8'h05);
  endtask
  task automatic cal_run(input int n, input logic tm);
    int k = 0;
    logic seen_tm = 1'b0;
    wr(ADDR_CAL_START, 8'h08);
    #1;
    while (cal_busy === 1'b1 && k < 2000) begin
      if (k == 2) `CHK(raw_out, STATIC_CODE)
      seen_tm |= timing_cal_active;
      k++;
      @(posedge mclk);
      #1;
    end
    `CHK(k, n)
    `CHK(seen_tm, tm)
    rchk(ADDR_CAL_START, 8'h00);
  endtask
  task automatic t_cal();
    cal_run(FG, 1'b0);
    wr(ADDR_LINK_CTRL, 8'h00);
    #1 `CHK(serial_link_on, 1'b0)
    wr(ADDR_LINK_CTRL, 8'h01);
    #1 `CHK(serial_link_on, 1'b1)
    wr(ADDR_TIMING_CFG, 8'h01);
    cal_run(FG + TM, 1'b1);
    wr(ADDR_TIMING_CFG, 8'h00);
  endtask
  task automatic t_bg();
    logic [NUM_CORES-1:0] prev;
    int swaps = 0;
    wr(ADDR_OFFSET_ADJ, 8'h12);
    #1 `CHK(offset_adjust_eff, 8'h12)
    wr(ADDR_BG_CAL_CFG, 8'h03);
    cal_run(FG, 1'b0);
    `CHK(core_powered, 5'h1F)
    `CHK(offset_adjust_eff, 8'h00)
    prev = core_online;
    repeat (5 * BG) begin
      @(posedge mclk);
      #1 `CHK($countones(core_online), 4)
      if (core_online !== prev) begin
        swaps++;
        `CHK(~core_online, {~prev[3:0], ~prev[4]})
      end
      prev = core_online;
    end
    `CHK(swaps, 5)
    wr(ADDR_BG_CAL_CFG, 8'h00);
    wr(ADDR_OFFSET_ADJ, 8'h00);
    #1 `CHK(core_powered, 5'h0F)
  endtask
  task automatic t_ddc();
    int f [7] = '{1, 4, 8, 10, 16, 20, 32};
    int k;
    @(posedge mclk);
    adc_sample <= 12'h3A5;
    ila_active <= 1'b1;
    for (int c = 0; c < 7; c++) begin
      wr(ADDR_DDC_CONFIG, 8'(c));
      #1 `CHK(ddc_active, c > 0)
      `CHK(nco_reset, c > 0)
      // First interval may be stale
      repeat (3) begin
        k = 0;
        do begin
          @(posedge mclk);
          #1 k++;
        end while (sample_out_valid !== 1'b1 && k < 64);
      end
      `CHK(k, f[c])
      if (c == 0) `CHK({raw_out, i_out, q_out}, {12'h3A5, 30'h0})
    end
    @(posedge mclk);
    ila_active <= 1'b0;
    #1 `CHK(nco_reset, 1'b0)
  endtask

  initial begin
    cyc(4);
    rst_n <= 1'b1;
    t_regs();
    t_capture();
    t_sweep();
    t_cal();
    t_bg();
    t_ddc();
    summarize();
  end
  initial begin
    cyc(60000);
    err_count++;
    summarize();
  end
endmodule
